// ===== pcm_buf2.sv
// two-entry valid/ready buffer for received sample words
`timescale 1ns/1ps
module pcm_buf2 (
  input wire logic mclk_in, // master clock
  input wire logic rst_in, // async reset, active high
  input wire logic clr_in, // synchronous flush
  input wire logic in_valid_in, // word offered
  input pcm_pkg::pcm_sample_t in_data_in, // offered word
  output logic in_ready_out, // room for a word
  output logic out_valid_out, // head word valid
  output pcm_pkg::pcm_sample_t out_data_out, // head word
  input wire logic out_ready_in // consumer takes head
);
  import pcm_pkg::*;

  pcm_sample_t mem [2];
  logic [1:0] vld;
  logic push;
  logic pop;

  // entry 0 is the head so outputs come straight from flops
  assign push = in_valid_in & ~vld[1];
  assign pop = vld[0] & out_ready_in;
  assign in_ready_out = ~vld[1];
  assign out_valid_out = vld[0];
  assign out_data_out = mem[0];

  ////////////////////////////////////////////////////////////////////////////
  // occupancy flags
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      vld <= 2'b00;
    end else if (clr_in) begin
      vld <= 2'b00;
    end else if (pop & vld[1]) begin
      vld <= 2'b01;
    end else if (pop) begin
      vld <= {1'b0, push};
    end else if (push) begin
      vld <= vld[0] ? 2'b11 : 2'b01;
    end
  end

  // storage; tail moves to head on a pop
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (pop & vld[1]) begin
      mem[0] <= mem[1];
    end else if (push & (pop | ~vld[0])) begin
      mem[0] <= in_data_in;
    end else if (push) begin
      mem[1] <= in_data_in;
    end
  end
endmodule : pcm_buf2

// ===== pcm_far_end.sv
// far-end model: codec driving ssi frames on both ports
`timescale 1ns/1ps
module pcm_far_end (
  output logic bclk_out, // bit clock
  output logic str_a_out, // port a strobe
  output logic str_b_out, // port b strobe
  output logic rx_a_out, // line receive data
  output logic rx_b_out, // mic send data
  input wire logic tx_a_in, // send out stream
  input wire logic tx_b_in // line receive out
);
  // clock stands low between frames
  initial begin
    bclk_out = 1'b0;
    str_a_out = 1'b0;
    str_b_out = 1'b0;
    rx_a_out = 1'b1;
    rx_b_out = 1'b0;
  end
  // one 124.9 us frame, 200 ns bits, data changed and captured on the rise
  task automatic run_frame(input logic [4:0] nbits, input logic [15:0] wa,
      input logic [15:0] wb, output logic [15:0] ca, output logic [15:0] cb);
    int i;
    ca = 16'h0000;
    cb = 16'h0000;
    for (i = int'(nbits) - 1; i >= 0; i--) begin
      bclk_out = 1'b1;
      str_a_out = 1'b1;
      str_b_out = 1'b1;
      rx_a_out = wa[i];
      rx_b_out = wb[i];
      ca = {ca[14:0], tx_a_in};
      cb = {cb[14:0], tx_b_in};
      #100 bclk_out = 1'b0;
      #100;
    end
    // released lines show the inverse so a stale bit cannot pass
    bclk_out = 1'b1;
    str_a_out = 1'b0;
    str_b_out = 1'b0;
    rx_a_out = ~rx_a_out;
    rx_b_out = ~rx_b_out;
    #100 bclk_out = 1'b0;
    #(125000 - (int'(nbits) + 1) * 200);
  endtask : run_frame
endmodule : pcm_far_end

// ===== pcm_pkg.sv
// package: constants and types shared by the pcm serial port files
package pcm_pkg;
  // clock rates and frame timing
  localparam int MCLK_HZ = 40_000_000;
  localparam int BCLK_TDM_HZ = 4_096_000;
  localparam int FRAME_US = 125;
  // tdm bit clocks per frame, derived from the frame time
  localparam int TDM_CLKS = (BCLK_TDM_HZ / 1000) * FRAME_US / 1000;
  // frame pulse quiet for two frames of bit clocks means ssi strobe mode
  localparam int SSI_GAP_CLKS = 2 * TDM_CLKS;
  localparam logic [10:0] SSI_GAP = 11'(SSI_GAP_CLKS);
  // word lengths in bits
  localparam logic [4:0] WORD8 = 5'h08;
  localparam logic [4:0] WORD16 = 5'h10;
  // synchroniser bit positions
  localparam int S_STBY = 0;
  localparam int S_LAW = 1;
  localparam int S_FMT = 2;
  localparam int S_FP = 3;
  localparam int S_BCLK = 4;
  localparam int S_STA = 5;
  localparam int S_STB = 6;
  localparam int S_MDA = 7;
  localparam int S_MDB = 8;
  localparam int S_RXA = 9;
  localparam int S_RXB = 10;
  localparam int SYNC_W = 11;
  // register offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_GCI = 0;
  localparam int CTRL_RXEN = 1;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam int ST_SSI = 0;
  localparam int ST_LAW = 1;
  localparam int ST_FMT = 2;
  localparam int ST_STBY = 3;
  localparam int ST_OVR = 4;
  // sign-magnitude to standard companded code masks
  localparam logic [7:0] MU_G711_MASK = 8'h7f;
  localparam logic [7:0] A_G711_MASK = 8'h55;
  // tdm timeslot per mode
  localparam logic [4:0] SLOT_MODE1 = 5'h00;
  localparam logic [4:0] SLOT_MODE2 = 5'h02;
  localparam logic [4:0] SLOT_MODE3 = 5'h01;
  localparam logic [4:0] SLOT_MODE4 = 5'h00;
  // tdm mode from {strobe pin, mode-select pin}
  typedef enum logic [1:0] {
    PCM_MODE1 = 2'b00,
    PCM_MODE2 = 2'b01,
    PCM_MODE3 = 2'b10,
    PCM_MODE4 = 2'b11
  } pcm_tdm_mode_t;
  // one sample word towards or from the core
  typedef struct packed {
    logic linear;
    logic law_a;
    logic [15:0] data;
  } pcm_sample_t;
endpackage : pcm_pkg

// ===== pcm_port.sv
// pcm serial port: two ssi or tdm ports with framing, companding format and buffering
//
// Contract
// - companding law is mu-law when the curve select pin is low, A-law when high, both ports.
// - companded codes are sign-magnitude when the format pin is low, standard G.711 when high.
// - the line receive input is taken as a 128 to 4096 kbps stream of 8 or 16 bit samples.
// - the microphone send input is taken as a 128 to 4096 kbps stream of 8 or 16 bit samples.
// - the send output stream shifts out the processed microphone signal at the same rates.
// - the line receive output stream shifts out the processed line signal at the same rates.
// - in tdm modes the frame pulse is active low in stream bus mode and active high in GCI mode.
// - both ports run in ssi strobe mode while the frame pulse pin is held low.
// - the logic runs from its own master clock, asynchronous to the 8 kHz frames.
// - while the standby reset pin is low the port stays reset in a quiet standby state.
// - in tdm modes each port picks timeslot and sample size from its strobe and mode pins.
`timescale 1ns/1ps
module pcm_port (
  input wire logic mclk_in, // 40 MHz master clock
  input wire logic rst_in, // async reset, active high
  input wire logic standby_reset_n_in, // pin reset, low = standby
  input wire logic companding_curve_select_in, // 0 mu-law, 1 A-law
  input wire logic code_format_select_in, // 0 sign-mag, 1 G.711
  input wire logic frame_pulse_in, // tdm frame pulse, low = ssi
  input wire logic tdm_system_clock_in, // shared bit clock pin
  input wire logic port_a_frame_strobe_in, // port a strobe / mode
  input wire logic port_b_frame_strobe_in, // port b strobe / mode
  input wire logic port_a_bus_mode_select_in, // port a tdm mode select
  input wire logic port_b_bus_mode_select_in, // port b tdm mode select
  input wire logic line_receive_in, // port a serial input
  input wire logic mic_send_in, // port b serial input
  output logic send_out_stream_out, // port a serial output
  output logic line_receive_out, // port b serial output
  input wire logic [3:0] reg_addr_in, // register byte address
  input wire logic [7:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  output logic [7:0] reg_rdata_out, // read data, next cycle
  output logic [1:0] rx_valid_out, // received word valid per port
  output pcm_pkg::pcm_sample_t rx_sample_out [2], // received word per port
  input wire logic [1:0] rx_ready_in, // core takes received word
  input wire logic [1:0] tx_valid_in, // core offers word to send
  input pcm_pkg::pcm_sample_t tx_sample_in [2], // word to send per port
  output logic [1:0] tx_ready_out // holding register free
);
  import pcm_pkg::*;

  logic [SYNC_W-1:0] async_pins;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic standby;
  logic bclk_d;
  logic bclk_fall;
  logic fp_act;
  logic [10:0] gap_cnt;
  logic ssi_mode;
  logic [8:0] clk_cnt;
  logic [8:0] next_cnt;
  logic [7:0] ctrl;
  logic [1:0] ovr;
  logic [1:0] ovr_set;
  logic [1:0] strb;
  logic [1:0] mdsel;
  logic [1:0] rxpin;
  logic [15:0] tx_shift [2];
  logic [7:0] status;

  // converts between sign-magnitude and standard companded code
  function automatic logic [7:0] pcm_code(input logic [7:0] c, input logic law_a,
                                          input logic g711);
    logic [7:0] mask;
    mask = law_a ? A_G711_MASK : MU_G711_MASK;
    pcm_code = g711 ? (c ^ mask) : c;
  endfunction : pcm_code

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; standby pin resets low so the port starts in standby
  assign async_pins = {mic_send_in, line_receive_in, port_b_bus_mode_select_in,
                       port_a_bus_mode_select_in, port_b_frame_strobe_in,
                       port_a_frame_strobe_in, tdm_system_clock_in, frame_pulse_in,
                       code_format_select_in, companding_curve_select_in,
                       standby_reset_n_in};

  generate
    for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
      // first stage feeds only the second
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= async_pins[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign standby = ~sync_b[S_STBY];
  assign strb = {sync_b[S_STB], sync_b[S_STA]};
  assign mdsel = {sync_b[S_MDB], sync_b[S_MDA]};
  assign rxpin = {sync_b[S_RXB], sync_b[S_RXA]};

  ////////////////////////////////////////////////////////////////////////////
  // bit clock edge finder; 40 MHz gives about ten samples per 4.096 MHz period
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bclk_d <= 1'b0;
    end else begin
      bclk_d <= sync_b[S_BCLK];
    end
  end
  assign bclk_fall = bclk_d & ~sync_b[S_BCLK];

  // frame pulse polarity follows the selected tdm flavour
  assign fp_act = ctrl[CTRL_GCI] ? sync_b[S_FP] : ~sync_b[S_FP];

  // ssi detect: no high level on the frame pulse pin for two frames
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_cnt <= '0;
      ssi_mode <= 1'b1;
    end else if (standby) begin
      gap_cnt <= '0;
      ssi_mode <= 1'b1;
    end else if (sync_b[S_FP]) begin
      gap_cnt <= '0;
      ssi_mode <= 1'b0;
    end else if (gap_cnt == SSI_GAP) begin
      ssi_mode <= 1'b1;
    end else if (bclk_fall) begin
      gap_cnt <= gap_cnt + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tdm frame position in bus clocks; two clocks per data bit
  assign next_cnt = fp_act ? 9'h000 : clk_cnt + 9'h001;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_cnt <= '0;
    end else if (standby | ssi_mode) begin
      clk_cnt <= '0;
    end else if (bclk_fall) begin
      clk_cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per port framing, shifting, holding and receive buffer
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      pcm_tdm_mode_t mode;
      logic [4:0] slot;
      logic len16;
      logic [7:0] pos;
      logic [7:0] start;
      logic [7:0] idx;
      logic in_win;
      logic strb_d;
      logic strb_fall;
      logic rx_ev;
      logic tx_adv;
      logic tx_load;
      logic rx_done;
      logic rx16;
      logic tx16;
      logic [4:0] ssi_cnt;
      logic [15:0] rx_shift;
      pcm_sample_t tx_hold;
      pcm_sample_t tx_word;
      logic tx_hold_vld;
      logic next_hold_vld;
      logic tx_rdy;
      logic push_vld;
      pcm_sample_t push_data;
      logic buf_rdy;

      // tdm mode and window from strobe and mode pins
      assign mode = pcm_tdm_mode_t'({strb[p], mdsel[p]});
      always_comb begin
        case (mode)
          PCM_MODE1: slot = SLOT_MODE1;
          PCM_MODE2: slot = SLOT_MODE2;
          PCM_MODE3: slot = SLOT_MODE3;
          PCM_MODE4: slot = SLOT_MODE4;
          default: slot = SLOT_MODE1;
        endcase
      end
      assign len16 = (mode == PCM_MODE4);
      assign pos = next_cnt[8:1];
      assign start = {slot, 3'b000};
      assign idx = pos - start;
      assign in_win = (pos >= start) & (idx < (len16 ? 8'h10 : 8'h08));
      assign strb_fall = strb_d & ~strb[p];

      // bit events: ssi shifts on bit clock falls inside the strobe
      always_comb begin
        if (ssi_mode) begin
          rx_ev = bclk_fall & strb[p];
          tx_adv = rx_ev;
          tx_load = strb_fall;
          rx_done = strb_fall & ((ssi_cnt == WORD8) | (ssi_cnt == WORD16));
          rx16 = (ssi_cnt == WORD16);
          tx16 = (ssi_cnt == WORD16);
        end else begin
          rx_ev = bclk_fall & next_cnt[0] & in_win;
          tx_adv = bclk_fall & ~next_cnt[0] & in_win & (idx != 8'h00);
          tx_load = bclk_fall & ~next_cnt[0] & in_win & (idx == 8'h00);
          rx_done = rx_ev & (idx == (len16 ? 8'h0f : 8'h07));
          rx16 = len16;
          tx16 = len16;
        end
      end

      // strobe edge and ssi strobe length
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          strb_d <= 1'b0;
          ssi_cnt <= '0;
        end else if (standby) begin
          strb_d <= 1'b0;
          ssi_cnt <= '0;
        end else begin
          strb_d <= strb[p];
          if (strb_fall) begin
            ssi_cnt <= '0;
          end else if (rx_ev & (ssi_cnt != 5'h1f)) begin
            ssi_cnt <= ssi_cnt + 5'h01;
          end
        end
      end

      // receive shift register, msb first
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          rx_shift <= '0;
        end else if (standby) begin
          rx_shift <= '0;
        end else if (rx_ev) begin
          rx_shift <= {rx_shift[14:0], rxpin[p]};
        end
      end

      // finished word goes to the buffer; 8-bit words leave as sign-magnitude
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          push_vld <= 1'b0;
          push_data <= '0;
        end else begin
          push_vld <= rx_done & ctrl[CTRL_RXEN] & ~standby;
          if (rx_done) begin
            push_data.linear <= rx16;
            push_data.law_a <= sync_b[S_LAW];
            push_data.data <= rx16 ? rx_shift :
                              {8'h00, pcm_code(rx_shift[7:0], sync_b[S_LAW], sync_b[S_FMT])};
          end
        end
      end
      // the serial side cannot stall, so a full buffer drops and flags
      assign ovr_set[p] = push_vld & ~buf_rdy;

      pcm_buf2 u_buf (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .clr_in(standby),
        .in_valid_in(push_vld),
        .in_data_in(push_data),
        .in_ready_out(buf_rdy),
        .out_valid_out(rx_valid_out[p]),
        .out_data_out(rx_sample_out[p]),
        .out_ready_in(rx_ready_in[p])
      );

      // transmit holding register; an empty one sends a zero word
      assign tx_word = tx_hold_vld ? tx_hold : '0;
      always_comb begin
        next_hold_vld = tx_hold_vld;
        if (tx_load) begin
          next_hold_vld = 1'b0;
        end
        if (tx_valid_in[p] & ~tx_hold_vld) begin
          next_hold_vld = 1'b1;
        end
      end

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          tx_hold <= '0;
          tx_hold_vld <= 1'b0;
          tx_rdy <= 1'b0;
        end else if (standby) begin
          tx_hold_vld <= 1'b0;
          tx_rdy <= 1'b0;
        end else begin
          tx_hold_vld <= next_hold_vld;
          tx_rdy <= ~next_hold_vld;
          if (tx_valid_in[p] & ~tx_hold_vld) begin
            tx_hold <= tx_sample_in[p];
          end
        end
      end
      assign tx_ready_out[p] = tx_rdy;

      // transmit shift register; pin shows bit 15
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          tx_shift[p] <= '0;
        end else if (standby) begin
          tx_shift[p] <= '0;
        end else if (tx_load) begin
          tx_shift[p] <= tx16 ? tx_word.data :
                         {pcm_code(tx_word.data[7:0], sync_b[S_LAW], sync_b[S_FMT]), 8'h00};
        end else if (tx_adv) begin
          tx_shift[p] <= {tx_shift[p][14:0], 1'b0};
        end
      end
    end
  endgenerate

  assign send_out_stream_out = tx_shift[0][15];
  assign line_receive_out = tx_shift[1][15];

  ////////////////////////////////////////////////////////////////////////////
  // register port: control, and status with write-one-to-clear overruns
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr_in & (reg_addr_in == REG_CTRL)) begin
      ctrl <= reg_wdata_in;
    end
  end

  // a new overrun in the clearing cycle survives the clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ovr <= 2'b00;
    end else if (reg_wr_in & (reg_addr_in == REG_STATUS)) begin
      ovr <= (ovr & ~reg_wdata_in[ST_OVR +: 2]) | ovr_set;
    end else begin
      ovr <= ovr | ovr_set;
    end
  end

  always_comb begin
    status = 8'h00;
    status[ST_SSI] = ssi_mode;
    status[ST_LAW] = sync_b[S_LAW];
    status[ST_FMT] = sync_b[S_FMT];
    status[ST_STBY] = standby;
    status[ST_OVR +: 2] = ovr;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in & (reg_addr_in == REG_CTRL)) begin
      reg_rdata_out <= ctrl;
    end else if (reg_rd_in & (reg_addr_in == REG_STATUS)) begin
      reg_rdata_out <= status;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule : pcm_port

// ===== pcm_port_props.sv
// checker: port-level properties of the pcm serial port
`timescale 1ns/1ps
module pcm_port_props (
  input wire logic mclk_in, // clock
  input wire logic rst_in, // reset
  input wire logic standby_reset_n_in, // standby pin
  input wire logic companding_curve_select_in, // law pin
  input wire logic code_format_select_in, // format pin
  input wire logic frame_pulse_in, // frame pulse
  input wire logic send_out_stream_out, // port a out
  input wire logic line_receive_out, // port b out
  input wire logic [3:0] reg_addr_in, // address
  input wire logic reg_rd_in, // read strobe
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic [1:0] rx_valid_out, // rx valid
  input pcm_pkg::pcm_sample_t rx_sample_out [2], // rx words
  input wire logic [1:0] rx_ready_in, // rx ready
  input wire logic [1:0] tx_valid_in, // tx valid
  input wire logic [1:0] tx_ready_out // tx ready
);
  import pcm_pkg::*;
  logic rd_st;
  // status read strobe, shared by the pin mirrors
  assign rd_st = reg_rd_in && reg_addr_in == REG_STATUS;
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb_m @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  AST_RST_QUIET: assert property ($fell(rst_in) |-> tx_ready_out == 2'b00)
    else $error("tx ready up at reset release");
  // two sync stages plus the clearing flop
  AST_STBY_PINS: assert property (!standby_reset_n_in [*4] |->
    !send_out_stream_out && !line_receive_out && tx_ready_out == 2'b00)
    else $error("serial pins live in standby");
  AST_STBY_RX: assert property (!standby_reset_n_in [*4] |-> rx_valid_out == 2'b00)
    else $error("rx words kept in standby");
  AST_LAW: assert property ($stable(companding_curve_select_in) [*4] ##0 rd_st |=>
    reg_rdata_out[ST_LAW] == $past(companding_curve_select_in))
    else $error("law pin not mirrored");
  AST_FMT: assert property ($stable(code_format_select_in) [*4] ##0 rd_st |=>
    reg_rdata_out[ST_FMT] == $past(code_format_select_in))
    else $error("format pin not mirrored");
  AST_TDM: assert property (frame_pulse_in [*4] ##0 rd_st |=> !reg_rdata_out[ST_SSI])
    else $error("ssi mode with frame pulse high");
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in != REG_CTRL &&
    reg_addr_in != REG_STATUS |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_RX_HOLD_A: assert property (standby_reset_n_in [*3] ##0 rx_valid_out[0] &&
    !rx_ready_in[0] |=> rx_valid_out[0] && $stable(rx_sample_out[0]))
    else $error("port a word lost while stalled");
  AST_RX_HOLD_B: assert property (standby_reset_n_in [*3] ##0 rx_valid_out[1] &&
    !rx_ready_in[1] |=> rx_valid_out[1] && $stable(rx_sample_out[1]))
    else $error("port b word lost while stalled");
  AST_TX_TAKE: assert property (tx_valid_in[0] && tx_ready_out[0] |=> !tx_ready_out[0])
    else $error("hold still free");
  C_RX_TAKE: cover property (rx_valid_out[0] && rx_ready_in[0]);
  C_TX_TAKE: cover property (tx_valid_in[1] && tx_ready_out[1]);
  C_STBY: cover property (!standby_reset_n_in ##1 standby_reset_n_in);
endmodule : pcm_port_props
bind pcm_port pcm_port_props u_props (.*);

// ===== testbench.sv
// testbench: ssi frames, registers, buffering and standby of the pcm port
`timescale 1ns/1ps
module testbench;
  import pcm_pkg::*;
  typedef struct packed {
    logic law;
    logic fmt;
    logic [4:0] width;
    logic [15:0] wa;
    logic [15:0] wb;
  } pcm_row_t;
  pcm_row_t rows [7];
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic stby_n = 1'b1;
  logic law = 1'b0;
  logic fmt = 1'b0;
  logic fpulse = 1'b0;
  logic bclk, str_a, str_b, rx_a, rx_b, tx_a, tx_b;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, d;
  logic [1:0] rx_valid, tx_ready;
  logic [1:0] rx_ready = 2'b00;
  logic [1:0] tx_valid = 2'b00;
  pcm_sample_t rx_sample [2];
  pcm_sample_t tx_sample [2] = '{18'h0, 18'h0};
  logic [15:0] ca, cb;
  int n_fail = 0;
  int total_checks = 0;
  int r;
  // master clock, unrelated to the far end bit clock
  always #12.5 mclk_in = ~mclk_in;
  //////////////////////////////////////////////////////////////////////////////
  pcm_far_end u_far (.bclk_out(bclk), .str_a_out(str_a), .str_b_out(str_b), .rx_a_out(rx_a),
    .rx_b_out(rx_b), .tx_a_in(tx_a), .tx_b_in(tx_b));
  // mode selects grounded, as ssi wants
  pcm_port u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .standby_reset_n_in(stby_n),
    .companding_curve_select_in(law), .code_format_select_in(fmt), .frame_pulse_in(fpulse),
    .tdm_system_clock_in(bclk), .port_a_frame_strobe_in(str_a), .port_b_frame_strobe_in(str_b),
    .port_a_bus_mode_select_in(1'b0), .port_b_bus_mode_select_in(1'b0),
    .line_receive_in(rx_a), .mic_send_in(rx_b), .send_out_stream_out(tx_a),
    .line_receive_out(tx_b), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_valid_out(rx_valid), .rx_sample_out(rx_sample),
    .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_sample_in(tx_sample),
    .tx_ready_out(tx_ready));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : reg_write
  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_read
  task automatic take(input logic [1:0] m);
    @(posedge mclk_in);
    rx_ready <= m;
    @(posedge mclk_in);
    rx_ready <= 2'b00;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask : take
  task automatic offer_tx(input logic [15:0] a, input logic [15:0] b);
    int i;
    for (i = 0; i < 400 && tx_ready !== 2'b11; i++) @(posedge mclk_in);
    @(posedge mclk_in);
    tx_valid <= 2'b11;
    tx_sample[0] <= {1'b1, law, a};
    tx_sample[1] <= {1'b1, law, b};
    @(posedge mclk_in);
    tx_valid <= 2'b00;
  endtask : offer_tx
  // companded words come back sign-magnitude, linear words untouched
  function automatic logic [15:0] exp_rx(input pcm_row_t row, input logic [15:0] w);
    logic [7:0] m;
    m = row.law ? A_G711_MASK : MU_G711_MASK;
    if (row.width == WORD16) return w;
    return {8'h00, row.fmt ? (w[7:0] ^ m) : w[7:0]};
  endfunction : exp_rx
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // watchdog: frames plus slack
  initial begin
    #2_000_000;
    n_fail++;
    give_verdict();
  end
  initial begin
    rows[0] = {1'b0, 1'b0, WORD8, 16'h0085, 16'h003c};
    rows[1] = {1'b1, 1'b0, WORD8, 16'h00a5, 16'h005a};
    rows[2] = {1'b0, 1'b1, WORD8, 16'h0012, 16'h00ff};
    rows[3] = {1'b1, 1'b1, WORD8, 16'h0080, 16'h0001};
    rows[4] = {1'b0, 1'b0, WORD16, 16'h1234, 16'hfedc};
    rows[5] = {1'b0, 1'b0, WORD16, 16'h8001, 16'h7ffe};
    rows[6] = {1'b0, 1'b0, 5'h0c, 16'h0abc, 16'h0123};
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    #1 chk({12'h0, rx_valid, tx_ready}, 16'h0);
    reg_read(REG_CTRL, d);
    chk({8'h0, d}, {8'h0, CTRL_RESET});
    reg_read(4'h8, d);
    chk({8'h0, d}, 16'h0);
    reg_write(4'h8, 8'hff);
    reg_write(REG_CTRL, 8'h03);
    reg_read(REG_CTRL, d);
    chk({8'h0, d}, 16'h0003);
    reg_write(REG_CTRL, CTRL_RESET);
    $display("test reset_regs done");
    for (r = 0; r < 7; r++) begin
      @(posedge mclk_in);
      law <= rows[r].law;
      fmt <= rows[r].fmt;
      repeat (4) @(posedge mclk_in);
      reg_read(REG_STATUS, d);
      chk({13'h0, d[2:0]}, {13'h0, rows[r].fmt, rows[r].law, 1'b1});
      offer_tx(rows[r].wa ^ 16'h5a5a, rows[r].wb ^ 16'ha5a5);
      u_far.run_frame(rows[r].width, rows[r].wa, rows[r].wb, ca, cb);
      chk({14'h0, rx_valid}, (rows[r].width == 5'h0c) ? 16'h0 : 16'h3);
      // a dropped odd-length word leaves the old head on the sample outputs
      if (rows[r].width != 5'h0c) begin
        chk(rx_sample[0].data, exp_rx(rows[r], rows[r].wa));
        chk(rx_sample[1].data, exp_rx(rows[r], rows[r].wb));
      end
      if (rows[r].width == WORD8) chk({15'h0, rx_sample[0].law_a}, {15'h0, rows[r].law});
      if (r > 0 && rows[r].width == WORD16 && rows[r - 1].width == WORD16) begin
        chk(ca, rows[r - 1].wa ^ 16'h5a5a);
        chk(cb, rows[r - 1].wb ^ 16'ha5a5);
      end
      take(2'b11);
      $display("test row %0d done", r);
    end
    // three frames into a stalled two-entry buffer: third word dropped
    @(posedge mclk_in);
    fmt <= 1'b0;
    for (r = 0; r < 3; r++) u_far.run_frame(WORD8, 16'h0011 + 16'(r), 16'h0022, ca, cb);
    reg_read(REG_STATUS, d);
    chk({14'h0, d[5:4]}, 16'h3);
    chk(rx_sample[0].data, 16'h0011);
    take(2'b11);
    chk(rx_sample[0].data, 16'h0012);
    take(2'b11);
    chk({14'h0, rx_valid}, 16'h0);
    reg_write(REG_STATUS, 8'h30);
    reg_read(REG_STATUS, d);
    chk({14'h0, d[5:4]}, 16'h0);
    $display("test overrun done");
    // frame pulse high leaves ssi; standby brings it back and quiets pins
    @(posedge mclk_in);
    fpulse <= 1'b1;
    repeat (4) @(posedge mclk_in);
    reg_read(REG_STATUS, d);
    chk({15'h0, d[ST_SSI]}, 16'h0);
    @(posedge mclk_in);
    fpulse <= 1'b0;
    stby_n <= 1'b0;
    repeat (6) @(posedge mclk_in);
    #1 chk({10'h0, rx_valid, tx_ready, tx_a, tx_b}, 16'h0);
    reg_read(REG_STATUS, d);
    chk({14'h0, d[ST_STBY], d[ST_SSI]}, 16'h3);
    @(posedge mclk_in);
    stby_n <= 1'b1;
    repeat (6) @(posedge mclk_in);
    reg_read(REG_STATUS, d);
    chk({15'h0, d[ST_STBY]}, 16'h0);
    $display("test standby done");
    give_verdict();
  end
endmodule : testbench
